/* hw/snv_regs.svh */
// Purpose: Encodings, field sizes and timing counts of the serial
//          shadowed memory link
// Assumes: Host-side clock mclk of 40 ns
// Notes:   Definitions only
`ifndef SNV_REGS_SVH
`define SNV_REGS_SVH

// Instruction layout: start bit, 4 address bits, 3 op code bits
`define SNV_ADDR_W 4
`define SNV_OP_W 3
`define SNV_WORD_W 16
`define SNV_WORDS 16
`define SNV_CNT_W 5
`define SNV_FRAME_W 24

// Bit counts inside one frame
`define SNV_BIT_RDCHK 5'h06
`define SNV_BIT_OP 5'h07
`define SNV_BIT_INSN 5'h08
`define SNV_BIT_LAST 5'h17
`define SNV_BIT_END 5'h18

// Op codes
`define SNV_OP_WDIS 3'h0
`define SNV_OP_SAVE 3'h1
`define SNV_OP_WRITE 3'h3
`define SNV_OP_WEN 3'h4
`define SNV_OP_LOAD 3'h5
`define SNV_OP_READ_HI 2'h3

// Times in ns and their cycle counts at mclk
`define SNV_MCLK_NS 40
`define SNV_PWRUP_INHIBIT_NS 200
`define SNV_SAVE_TIME_NS 10000000
`define SNV_SCK_HALF_NS 500
`define SNV_CS_GAP_NS 800
`define SNV_PWRUP_CYC \
    ((`SNV_PWRUP_INHIBIT_NS + `SNV_MCLK_NS - 1) / `SNV_MCLK_NS)
`define SNV_SAVE_CYC (`SNV_SAVE_TIME_NS / `SNV_MCLK_NS)
`define SNV_HALF_CYC \
    ((`SNV_SCK_HALF_NS + `SNV_MCLK_NS - 1) / `SNV_MCLK_NS)
`define SNV_GAP_CYC ((`SNV_CS_GAP_NS + `SNV_MCLK_NS - 1) / `SNV_MCLK_NS)
`define SNV_TIMER_W 20

`endif

/* hw/snv_pkg.sv */
// Purpose: Shared types and decode for both ends of the link
// Assumes: snv_regs.svh holds the numbers
// Notes:   None
`include "snv_regs.svh"

package snv_pkg;

    typedef enum logic [1:0] {SNV_PWRUP, SNV_IDLE, SNV_SAVING} snv_dev_st_t;
    typedef enum logic [1:0] {SNV_H_IDLE, SNV_H_LOW, SNV_H_HIGH} snv_host_st_t;

    // Read is 11x: the last op bit is never looked at
    function automatic logic snv_is_read(input logic [2:0] op);
        return op[2:1] == `SNV_OP_READ_HI;
    endfunction

    function automatic logic snv_has_data(input logic [2:0] op);
        return snv_is_read(op) || op == `SNV_OP_WRITE;
    endfunction

endpackage

/* hw/snv_link_if.sv */
// Purpose: Serial link between host and shadowed memory device
// Assumes: Host makes the serial clock
// Notes:   Data out line idles high when released
`timescale 1ns/10ps

interface snv_link_if;
    logic serialClock;
    logic chipSelect;
    logic dataIn;
    logic dataOut;
    logic dataOutEnN;
    wire doLine = dataOutEnN ? 1'b1 : dataOut;

    modport dev(input serialClock, input chipSelect, input dataIn,
                output dataOut, output dataOutEnN);
    modport host(output serialClock, output chipSelect, output dataIn,
                 input doLine);
endinterface

/* hw/snv_device.sv */
// Purpose: Device end: serial instruction decoder, volatile word array,
//          nonvolatile copy, save and reload control
// Assumes: Host keeps serial clock half periods of at least 400 ns
// Notes:   Serial logic runs on the link clock, arrays on mclk
`timescale 1ns/10ps
`include "snv_regs.svh"

// Functional notes
// R1 - Start bit, four address, three op bits
// R2 - Op 000 clears, 100 sets write latch
// R3 - Op 001 saves, 101 reloads whole array
// R4 - Op 011 writes word, 11x reads word
// R5 - Input bits sampled on rising clock
// R6 - Output released except while reading out
// R7 - Select low discards instruction, clears shifter
// R8 - Write takes sixteen data bits after instruction
// R9 - Read bits from falling eighth, then rising
// R10 - Eighth bit of read is ignored
// R11 - Host gives exactly sixteen data clocks
// R12 - Shift state held while clock stops
// R13 - Sixteen by sixteen array, nonvolatile mirror
// R14 - Write latch clear at power-up
// R15 - Write latch set until disable, save, power
// R16 - Reads ignore write latch
// R17 - Reload by instruction or pin; sets recall
// R18 - Reload needed before writes or saves
// R19 - Power-up reload, operations refused briefly
// R20 - Save needs recall, latch and request
// R21 - Save blocks all; clears write latch
// R22 - Low supply blocks saves, clears latch
// R23 - Save wins over other requests
// R24 - Low supply is a single input
module snv_device
    import snv_pkg::*;
#(
    parameter int SAVE_CYCLES = `SNV_SAVE_CYC
)(
    snv_link_if.dev link,           // Serial link
    input wire logic mclk,          // Array clock
    input wire logic srst,          // Power-on reset
    input wire logic saveReqN,      // Hardware save pin
    input wire logic reloadReqN,    // Hardware reload pin
    input wire logic lowSupply,     // Supply below save threshold
    output logic busy,              // Power-up or save running
    output logic writeEnabled,      // Write-enable latch
    output logic recallDone         // Previous-recall latch
);

////////////////////////////////////////////////////////////////////////////
// Link clock domain

    logic [`SNV_CNT_W-1:0] bitCnt_ff;
    logic [`SNV_CNT_W-1:0] nxt_bitCnt;
    logic [6:0] insn_ff;
    logic [`SNV_WORD_W-1:0] wdata_ff;
    logic [`SNV_OP_W-1:0] cmdOp_ff;
    logic [`SNV_ADDR_W-1:0] cmdAddr_ff;
    logic [`SNV_WORD_W-1:0] cmdData_ff;
    logic cmdTgl_ff;
    logic rdOe_ff;
    logic [`SNV_WORD_W-1:0] rdHold_ff;
    logic [`SNV_WORD_W-1:0] readWord_ff;

    wire [6:0] nxtInsn = {insn_ff[5:0], link.dataIn};
    wire startSeen = bitCnt_ff == '0 && link.dataIn;
    wire inInsn = bitCnt_ff != '0 && bitCnt_ff < `SNV_BIT_INSN;
    wire inData = bitCnt_ff >= `SNV_BIT_INSN && bitCnt_ff < `SNV_BIT_END;
    wire dataOp = snv_has_data(insn_ff[2:0]);
    // Read is known one bit early so the word can be fetched in time
    wire rdIssue = bitCnt_ff == `SNV_BIT_RDCHK
        && nxtInsn[1:0] == `SNV_OP_READ_HI;
    wire modeIssue = bitCnt_ff == `SNV_BIT_OP
        && !snv_has_data(nxtInsn[2:0]);
    wire wrIssue = bitCnt_ff == `SNV_BIT_LAST
        && insn_ff[2:0] == `SNV_OP_WRITE;
    wire issue = rdIssue || modeIssue || wrIssue;

    always_comb
    begin
        nxt_bitCnt = bitCnt_ff;
        if (startSeen || inInsn || (inData && dataOp))  // see R1 see R11
        begin
            nxt_bitCnt = bitCnt_ff + 5'h01;
        end
    end

    // Select low clears the count and both shift registers; no edge means no change
    always_ff @(posedge link.serialClock or negedge link.chipSelect)
    begin
        if (!link.chipSelect)                           // see R7 see R12
        begin
            bitCnt_ff <= '0;
            insn_ff <= '0;
            wdata_ff <= '0;
        end
        else                                            // see R5
        begin
            bitCnt_ff <= nxt_bitCnt;
            if (inInsn)
            begin
                insn_ff <= nxtInsn;                     // see R10
            end
            if (inData)
            begin
                wdata_ff <= {wdata_ff[14:0], link.dataIn};  // see R8
            end
        end
    end

    // Command words stay put until the next issue, long after mclk uses them.
    // srst clears the toggle while the link clock stands still in reset.
    always_ff @(posedge link.serialClock or posedge srst)
    begin
        if (srst)
        begin
            cmdTgl_ff <= 1'b0;
            cmdOp_ff <= '0;
            cmdAddr_ff <= '0;
            cmdData_ff <= '0;
        end
        else if (link.chipSelect && issue)
        begin
            cmdTgl_ff <= !cmdTgl_ff;
            cmdOp_ff <= wrIssue ? `SNV_OP_WRITE
                : (rdIssue ? {nxtInsn[1:0], 1'b0} : nxtInsn[2:0]);
            cmdAddr_ff <= (modeIssue || rdIssue) ? nxtInsn[5:2] :
                insn_ff[6:3];
            cmdData_ff <= {wdata_ff[14:0], link.dataIn};
        end
    end

    // First read bit leaves on the falling edge of the eighth clock
    always_ff @(negedge link.serialClock or negedge link.chipSelect)
    begin
        if (!link.chipSelect)
        begin
            rdOe_ff <= 1'b0;
        end
        else if (bitCnt_ff == `SNV_BIT_INSN && snv_is_read(insn_ff[2:0]))
        begin
            rdOe_ff <= 1'b1;                            // see R9
            rdHold_ff <= readWord_ff;
        end
    end

    wire [`SNV_CNT_W-1:0] outPos = `SNV_BIT_LAST - bitCnt_ff;
    assign link.dataOut = rdHold_ff[outPos[3:0]];       // see R9
    assign link.dataOutEnN = !(rdOe_ff && inData);      // see R6

////////////////////////////////////////////////////////////////////////////
// mclk domain

    logic [2:0] tglSync_ff;
    logic [2:0] pinSync1_ff;
    logic [2:0] pinSync2_ff;
    snv_dev_st_t state_ff;
    snv_dev_st_t nxt_state;
    logic [`SNV_TIMER_W-1:0] timer_ff;
    logic [`SNV_TIMER_W-1:0] nxt_timer;
    logic pend_ff;
    logic wel_ff;
    logic nxt_wel;
    logic prevRc_ff;
    logic [`SNV_WORD_W-1:0] vol_ff [`SNV_WORDS];
    logic [`SNV_WORD_W-1:0] nv_ff [`SNV_WORDS];

    always_ff @(posedge mclk)
    begin
        tglSync_ff <= {tglSync_ff[1:0], cmdTgl_ff};
        pinSync1_ff <= {lowSupply, reloadReqN, saveReqN};
        pinSync2_ff <= pinSync1_ff;
    end

    wire cmdEvt = tglSync_ff[2] ^ tglSync_ff[1];
    wire saveReq = !pinSync2_ff[0];
    wire reloadReq = !pinSync2_ff[1];
    wire lowSync = pinSync2_ff[2];                      // see R24
    wire isIdle = state_ff == SNV_IDLE;
    wire timerZero = timer_ff == '0;
    wire pendSave = pend_ff && cmdOp_ff == `SNV_OP_SAVE;
    wire pendLoad = pend_ff && cmdOp_ff == `SNV_OP_LOAD;
    // see R20 see R22 see R23
    wire saveGo = isIdle && prevRc_ff && wel_ff && !lowSync
        && (saveReq || pendSave);
    // A queued non-save command waits behind a save
    wire cmdTake = isIdle && pend_ff && (!saveGo || pendSave);
    wire doRecall = (state_ff == SNV_PWRUP && timerZero)     // see R19
        || (isIdle && !saveGo && (reloadReq || pendLoad));   // see R17
    wire doWrite = cmdTake && cmdOp_ff == `SNV_OP_WRITE
        && wel_ff && prevRc_ff;                         // see R18
    wire saveDone = state_ff == SNV_SAVING && timerZero;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_timer = timerZero ? timer_ff : timer_ff - 1'b1;
        unique case (state_ff)
            SNV_PWRUP:
            begin
                if (timerZero)
                begin
                    nxt_state = SNV_IDLE;
                end
            end
            SNV_IDLE:
            begin
                if (saveGo)
                begin
                    nxt_state = SNV_SAVING;
                    nxt_timer = `SNV_TIMER_W'(SAVE_CYCLES - 1);
                end
            end
            SNV_SAVING:
            begin
                if (timerZero)                          // see R21
                begin
                    nxt_state = SNV_IDLE;
                end
            end
        endcase
    end

    always_comb
    begin
        nxt_wel = wel_ff;
        if (cmdTake && cmdOp_ff == `SNV_OP_WEN)
        begin
            nxt_wel = 1'b1;                             // see R2
        end
        if ((cmdTake && cmdOp_ff == `SNV_OP_WDIS) || saveDone || lowSync)
        begin
            nxt_wel = 1'b0;                             // see R15 see R22
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            state_ff <= SNV_PWRUP;
            timer_ff <= `SNV_TIMER_W'(`SNV_PWRUP_CYC);
            pend_ff <= 1'b0;
            wel_ff <= 1'b0;                             // see R14
            prevRc_ff <= 1'b0;
            readWord_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            timer_ff <= nxt_timer;
            // Commands arriving while busy are refused, not queued
            pend_ff <= (pend_ff && !cmdTake) || (cmdEvt && isIdle);
            wel_ff <= nxt_wel;
            prevRc_ff <= prevRc_ff || doRecall;
            if (cmdTake && snv_is_read(cmdOp_ff))       // see R4 see R16
            begin
                readWord_ff <= vol_ff[cmdAddr_ff];
            end
        end
    end

    // Nonvolatile words carry no reset: they survive power cycles
    for (genvar i = 0; i < `SNV_WORDS; i++)
    begin : g_word
        always_ff @(posedge mclk)
        begin
            if (doRecall)                               // see R3 see R13
            begin
                vol_ff[i] <= nv_ff[i];
            end
            else if (doWrite && cmdAddr_ff == `SNV_ADDR_W'(i))
            begin
                vol_ff[i] <= cmdData_ff;                // see R4 see R8
            end
            if (saveGo)
            begin
                nv_ff[i] <= vol_ff[i];                  // see R3
            end
        end
    end

    assign busy = !isIdle;
    assign writeEnabled = wel_ff;
    assign recallDone = prevRc_ff;

endmodule // snv_device

/* hw/snv_host.sv */
// Purpose: Host end: sends one instruction frame per request and
//          returns read words
// Assumes: Serial clock made from mclk by a divider
// Notes:   One request in flight; reqReady low while a frame runs
`timescale 1ns/10ps
`include "snv_regs.svh"

module snv_host
    import snv_pkg::*;
#(
    parameter int HALF_CYCLES = `SNV_HALF_CYC,
    parameter int GAP_CYCLES = `SNV_GAP_CYC
)(
    snv_link_if.host link,          // Serial link
    input wire logic mclk,          // System clock
    input wire logic srst,          // Synchronous reset
    input wire logic reqValid,      // Request present
    output logic reqReady,          // Request taken when both high
    input wire logic [2:0] reqOp,   // Op code
    input wire logic [3:0] reqAddr, // Word address
    input wire logic [15:0] reqData, // Write word
    output logic rspValid,          // Read word pulse
    output logic [15:0] rspData     // Read word
);

////////////////////////////////////////////////////////////////////////////
// Frame sequencer

    snv_host_st_t state_ff;
    logic [`SNV_TIMER_W-1:0] halfCnt_ff;
    logic [`SNV_CNT_W-1:0] bitCnt_ff;
    logic [`SNV_CNT_W-1:0] nBits_ff;
    logic [`SNV_FRAME_W-1:0] shOut_ff;
    logic isRd_ff;
    logic [15:0] rdData_ff;
    logic rspValid_ff;
    logic cs_ff;
    logic sck_ff;
    logic doSync1_ff;
    logic doSync2_ff;

    wire take = reqValid && reqReady;
    wire halfDone = halfCnt_ff == '0;
    wire lastBit = bitCnt_ff + 5'h01 == nBits_ff;
    // Read bits are sampled just before the rises that follow the eighth
    wire sampleRd = isRd_ff && bitCnt_ff >= `SNV_BIT_INSN;

    always_ff @(posedge mclk)
    begin
        doSync1_ff <= link.doLine;
        doSync2_ff <= doSync1_ff;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            state_ff <= SNV_H_IDLE;
            halfCnt_ff <= '0;
            bitCnt_ff <= '0;
            nBits_ff <= `SNV_BIT_INSN;
            shOut_ff <= '0;
            isRd_ff <= 1'b0;
            rdData_ff <= '0;
            rspValid_ff <= 1'b0;
            cs_ff <= 1'b0;
            sck_ff <= 1'b0;
        end
        else
        begin
            rspValid_ff <= 1'b0;
            halfCnt_ff <= halfDone ? halfCnt_ff : halfCnt_ff - 1'b1;
            unique case (state_ff)
                SNV_H_IDLE:
                begin
                    // Deselect spacing is waited out before select; set-up time counted after it
                    if (take && halfDone)
                    begin
                        state_ff <= SNV_H_LOW;
                        halfCnt_ff <= `SNV_TIMER_W'(GAP_CYCLES - 1);
                        cs_ff <= 1'b1;
                        bitCnt_ff <= '0;
                        shOut_ff <= {1'b1, reqAddr, reqOp, reqData};
                        nBits_ff <= snv_has_data(reqOp) ? `SNV_BIT_END :
                            `SNV_BIT_INSN;
                        isRd_ff <= snv_is_read(reqOp);
                    end
                end
                SNV_H_LOW:
                begin
                    if (halfDone)
                    begin
                        state_ff <= SNV_H_HIGH;
                        halfCnt_ff <= `SNV_TIMER_W'(HALF_CYCLES - 1);
                        sck_ff <= 1'b1;
                        if (sampleRd)
                        begin
                            rdData_ff <= {rdData_ff[14:0], doSync2_ff};
                        end
                    end
                end
                SNV_H_HIGH:
                begin
                    if (halfDone)
                    begin
                        sck_ff <= 1'b0;
                        bitCnt_ff <= bitCnt_ff + 5'h01;
                        shOut_ff <= {shOut_ff[22:0], 1'b0};
                        state_ff <= lastBit ? SNV_H_IDLE : SNV_H_LOW;
                        halfCnt_ff <= lastBit ?
                            `SNV_TIMER_W'(GAP_CYCLES - 1) :
                            `SNV_TIMER_W'(HALF_CYCLES - 1);
                        cs_ff <= !lastBit;
                        rspValid_ff <= lastBit && isRd_ff;
                    end
                end
                default:
                begin
                    state_ff <= SNV_H_IDLE;
                end
            endcase
        end
    end

    assign reqReady = state_ff == SNV_H_IDLE && halfDone;
    assign rspValid = rspValid_ff;
    assign rspData = rdData_ff;
    assign link.serialClock = sck_ff;
    assign link.chipSelect = cs_ff;
    assign link.dataIn = shOut_ff[`SNV_FRAME_W-1];

endmodule // snv_host

/* bench/snv_link_sva.sv */
// Purpose: Wire and latch checks between the host and device ends
// Assumes: Host registers the serial clock on mclk
// Notes:   Interface signals come in as plain inputs
`timescale 1ns/10ps

module snv_link_sva (
    input wire logic mclk,         // Clock
    input wire logic srst,         // Reset
    input wire logic serialClock,  // Link clock
    input wire logic chipSelect,   // Frame select
    input wire logic dataIn,       // Host bit
    input wire logic dataOut,      // Device bit
    input wire logic dataOutEnN,   // Device drive, active low
    input wire logic lowSupply,    // Low supply input
    input wire logic busy,         // Device busy
    input wire logic writeEnabled  // Write latch
);
    logic sckQ_ff;
    logic [4:0] rises_ff;
    wire sckRise = serialClock && !sckQ_ff;
    wire [4:0] nxt_rises = !chipSelect ? 5'h00 : rises_ff + {4'h0, sckRise};

    // Rises are counted on mclk, safe since the host makes the clock there
    always_ff @(posedge mclk)
    begin
        sckQ_ff <= serialClock;
        rises_ff <= nxt_rises;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    AST_DO_RELEASED: assert property (!chipSelect |-> dataOutEnN)
        else $error("data out driven outside a frame");
    AST_SCK_IDLE: assert property (!chipSelect |-> !serialClock)
        else $error("serial clock runs without select");
    AST_DO_WINDOW: assert property (!dataOutEnN |->
        rises_ff inside {[5'h08:5'h17]})
        else $error("data out driven outside the read word");
    AST_DO_STEP: assert property (!dataOutEnN && $changed(dataOut) |->
        $rose(serialClock) || $fell(dataOutEnN))
        else $error("read bit changed off its clock edge");
    AST_DIN_STABLE: assert property (serialClock |-> $stable(dataIn))
        else $error("data in moved while clock high");
    AST_WE_RESET: assert property (disable iff (1'b0)
        srst |=> !writeEnabled)
        else $error("write latch set after reset");
    AST_LOW_SUPPLY: assert property (lowSupply [*4] |=>
        !writeEnabled && !$rose(busy))
        else $error("latch or save alive at low supply");
    AST_SAVE_END: assert property ($fell(busy) |->
        ##[0:1] !writeEnabled)
        else $error("write latch kept after save");
    AST_SAVE_NEEDS_WE: assert property ($rose(busy) |-> writeEnabled)
        else $error("save started with latch clear");
    AST_FRAME_LEN: assert property ($fell(chipSelect) |->
        rises_ff inside {5'h08, 5'h18})
        else $error("frame ended off a whole word");

    cover property ($fell(dataOutEnN));
    cover property ($rose(busy));
    cover property (lowSupply && $fell(writeEnabled));
endmodule // snv_link_sva

/* bench/serial_nvram_store_recall_tb_top.sv */
// Purpose: Self-checking bench for host and device ends of the link
// Assumes: Save time shortened by parameter
// Notes:   A second device is driven by hand to break frame rules
`timescale 1ns/10ps

module serial_nvram_store_recall_tb_top;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic saveReqN = 1'b1;
    logic reloadReqN = 1'b1;
    logic lowSupply = 1'b0;
    logic reqValid = 1'b0;
    logic [2:0] reqOp = 3'h0;
    logic [3:0] reqAddr = 4'h0;
    logic [15:0] reqData = 16'h0000;
    logic reqReady, rspValid, busy, writeEnabled, recallDone, weB;
    logic busyB, rcB;
    logic [15:0] rspData, val;
    logic [15:0] mem [16];
    logic [15:0] nv [16];
    logic [15:0] expQ [$];
    int error_cnt = 0;
    int check_count = 0;
    integer seed = 32'h264d4bfd;

    snv_link_if linkA();
    snv_link_if linkB();

    snv_host #(.HALF_CYCLES(13), .GAP_CYCLES(20)) snv_host_i (
        .link(linkA.host), .mclk(mclk), .srst(srst), .reqValid(reqValid),
        .reqReady(reqReady), .reqOp(reqOp), .reqAddr(reqAddr),
        .reqData(reqData), .rspValid(rspValid), .rspData(rspData));
    snv_device #(.SAVE_CYCLES(20)) snv_device_i (
        .link(linkA.dev), .mclk(mclk), .srst(srst), .saveReqN(saveReqN),
        .reloadReqN(reloadReqN), .lowSupply(lowSupply), .busy(busy),
        .writeEnabled(writeEnabled), .recallDone(recallDone));
    snv_device #(.SAVE_CYCLES(20)) snv_device_b_i (
        .link(linkB.dev), .mclk(mclk), .srst(srst), .saveReqN(saveReqN),
        .reloadReqN(reloadReqN), .lowSupply(lowSupply), .busy(busyB),
        .writeEnabled(weB), .recallDone(rcB));
    snv_link_sva snv_link_sva_i (.mclk(mclk), .srst(srst),
        .serialClock(linkA.serialClock), .chipSelect(linkA.chipSelect),
        .dataIn(linkA.dataIn), .dataOut(linkA.dataOut),
        .dataOutEnN(linkA.dataOutEnN), .lowSupply(lowSupply),
        .busy(busy), .writeEnabled(writeEnabled));

    initial
    begin
        forever #20 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Returns once the frame and its deselect gap are over
    task automatic send(input logic [2:0] op, input logic [3:0] a,
                        input logic [15:0] d);
        int n;
        n = 0;
        @(negedge mclk);
        reqValid = 1'b1;
        reqOp = op;
        reqAddr = a;
        reqData = d;
        while (reqReady !== 1'b1 && n < 3000)
        begin
            @(negedge mclk);
            n++;
        end
        @(negedge mclk);
        reqValid = 1'b0;
        while (reqReady !== 1'b1 && n < 3000)
        begin
            @(negedge mclk);
            n++;
        end
    endtask

    // Odd addresses use the read code with its last bit set
    task automatic rd(input logic [3:0] a);
        expQ.push_back(mem[a]);
        send({2'b11, a[0]}, a, 16'h0000);
    endtask

    task automatic waitBusy(input logic level);
        for (int n = 0; n < 300 && busy !== level; n++)
            @(negedge mclk);
    endtask

    task automatic shiftB(input logic [7:0] insn, input int hi, input int lo);
        for (int i = hi; i >= lo; i--)
        begin
            linkB.dataIn = insn[i];
            #3 linkB.serialClock = 1'b1;
            #3 linkB.serialClock = 1'b0;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(negedge mclk)
    begin
        if (rspValid === 1'b1 && expQ.size() > 0)
            check(rspData, expQ.pop_front());
        else if (rspValid === 1'b1)
            check(rspData, ~rspData);
    end

    initial
    begin
        repeat (60000) @(posedge mclk);
        error_cnt++;
        results();
    end

    initial
    begin
        linkB.chipSelect = 1'b0;
        linkB.serialClock = 1'b0;
        linkB.dataIn = 1'b0;
        repeat (8) @(negedge mclk);
        srst = 1'b0;
        waitBusy(1'b0);
        check(writeEnabled, 1'b0);
        check(recallDone, 1'b1);
        send(3'h4, 4'h0, 16'h0000);
        check(writeEnabled, 1'b1);
        for (int i = 0; i < 16; i++)
        begin
            val = $random(seed);
            mem[i] = val;
            send(3'h3, i[3:0], val);
        end
        for (int i = 15; i >= 0; i--)
            rd(i[3:0]);
        send(3'h0, 4'h5, 16'h0000);
        check(writeEnabled, 1'b0);
        send(3'h3, 4'h5, ~mem[5]);
        rd(4'h5);
        send(3'h4, 4'h0, 16'h0000);
        send(3'h1, 4'hf, 16'h0000);
        nv = mem;
        waitBusy(1'b0);
        check(writeEnabled, 1'b0);
        send(3'h4, 4'h0, 16'h0000);
        send(3'h3, 4'h2, ~nv[2]);
        mem[2] = ~nv[2];
        rd(4'h2);
        send(3'h5, 4'h9, 16'h0000);
        mem = nv;
        rd(4'h2);
        send(3'h3, 4'h4, ~nv[4]);
        reloadReqN = 1'b0;
        repeat (6) @(negedge mclk);
        reloadReqN = 1'b1;
        rd(4'h4);
        lowSupply = 1'b1;
        repeat (6) @(negedge mclk);
        check(writeEnabled, 1'b0);
        saveReqN = 1'b0;
        repeat (6) @(negedge mclk);
        check(busy, 1'b0);
        saveReqN = 1'b1;
        repeat (4) @(negedge mclk);
        lowSupply = 1'b0;
        send(3'h4, 4'h0, 16'h0000);
        val = $random(seed);
        send(3'h3, 4'h7, val);
        mem[7] = val;
        saveReqN = 1'b0;
        waitBusy(1'b1);
        check(busy, 1'b1);
        saveReqN = 1'b1;
        waitBusy(1'b0);
        nv = mem;
        check(writeEnabled, 1'b0);
        send(3'h4, 4'h0, 16'h0000);
        send(3'h3, 4'h7, ~val);
        send(3'h5, 4'h0, 16'h0000);
        rd(4'h7);
        // Hand-driven link: a cut frame must leave nothing behind
        linkB.chipSelect = 1'b1;
        shiftB(8'h84, 7, 3);
        linkB.chipSelect = 1'b0;
        #100 linkB.chipSelect = 1'b1;
        shiftB(8'h84, 2, 0);
        #400 linkB.chipSelect = 1'b0;
        repeat (10) @(negedge mclk);
        check(weB, 1'b0);
        linkB.chipSelect = 1'b1;
        shiftB(8'h84, 7, 3);
        #2000 shiftB(8'h84, 2, 0);
        #400 linkB.chipSelect = 1'b0;
        repeat (10) @(negedge mclk);
        check(weB, 1'b1);
        check(busyB, 1'b0);
        check(rcB, 1'b1);
        check(16'(expQ.size()), 16'h0000);
        results();
    end
endmodule // serial_nvram_store_recall_tb_top
